// File: pkg/ptp_calc_if.sv
// carrier between the top and its signature and group-chain helpers
`timescale 1ns/1ps
`default_nettype none
interface ptp_calc_if;
  import ptp_calc_pkg::*;
  logic [8*HDR_BYTES-1:0]   hdr;
  logic [8*ADDR_BYTES-1:0]  addr;
  logic [MAP_W*SIG_BYTES-1:0] map;
  logic [8*SIG_BYTES-1:0]   sig;
  logic [1:0]               grp_first;
  logic [STAGES-1:0]        stage_a;
  logic [STAGES-1:0]        stage_b;
  logic [2*(STAGES+1)-1:0]  grp_chain;

  modport builder (input hdr, input addr, input map, output sig);
  modport chain   (input grp_first, input stage_a, input stage_b, output grp_chain);
  modport owner   (output hdr, output addr, output map, input sig,
                   output grp_first, output stage_a, output stage_b, input grp_chain);
endinterface
`default_nettype wire

// File: pkg/ptp_calc_pkg.sv
// constants and types shared by the signature and time stamp logic
package ptp_calc_pkg;

  // ----------------------------------------
  // frame signature
  // ----------------------------------------
  localparam int        SIG_BYTES    = 16;
  localparam int        MAP_W        = 6;
  localparam int        HDR_BYTES    = 32;
  localparam int        ADDR_BYTES   = 8;
  localparam int        CMP_COUNT    = 4;
  localparam logic [5:0] SEL_HDR_MAX  = 6'h17;
  localparam logic [5:0] SEL_HDR_BASE = 6'h1F;
  localparam logic [5:0] SEL_HDR6     = 6'h18;
  localparam logic [5:0] SEL_HDR4     = 6'h19;
  localparam logic [5:0] SEL_HDR0     = 6'h1A;
  localparam logic [5:0] SEL_ADDR_LO  = 6'h1C;
  localparam logic [5:0] SEL_ADDR_HI  = 6'h23;
  localparam logic [4:0] HDR_IDX6     = 5'h06;
  localparam logic [4:0] HDR_IDX4     = 5'h04;
  localparam logic [4:0] HDR_IDX0     = 5'h00;
  localparam logic [1:0] ADR_FIRST_ETHERNET_COMPARATOR     = 2'h0;
  localparam logic [1:0] ADR_SECOND_ETHERNET_COMPARATOR     = 2'h1;
  localparam logic [1:0] ADR_IP1      = 2'h2;
  localparam logic [1:0] ADR_IP2      = 2'h3;

  // ----------------------------------------
  // flows and protocol groups
  // ----------------------------------------
  localparam int FLOWS    = 8;
  localparam int CHANNELS = 2;
  localparam int STAGES   = 3;

  // ----------------------------------------
  // time stamp arithmetic
  // ----------------------------------------
  localparam logic [31:0] NS_PER_SEC = 32'h3B9ACA00;
  localparam int          FRAC_BITS  = 16;

  typedef struct packed {
    logic [47:0] sec;
    logic [31:0] ns;
  } ts_s;

  typedef enum logic {
    CMD_TIMESTAMP,
    CMD_CORRECTION
  } tsp_cmd_e;

endpackage

// File: rtl/proto_group_chain.sv
// protocol-group match bits carried from stage to stage
`timescale 1ns/1ps
`default_nettype none
module proto_group_chain (
  ptp_calc_if.chain bus  // per-stage group matches in; chained groups out
);
  import ptp_calc_pkg::*;

  assign bus.grp_chain[1:0] = bus.grp_first;

  // a later stage can only confirm groups its predecessor already flagged
  genvar s;
  generate
    for (s = 0; s < STAGES; s++) begin : g_stage
      assign bus.grp_chain[2*(s+1) +: 2] =
        bus.grp_chain[2*s +: 2] & {bus.stage_b[s], bus.stage_a[s]};
    end
  endgenerate
endmodule
`default_nettype wire

// File: rtl/ptp_signature_and_timestamp_calc.sv
// frame signature builder, protocol-group gating and time stamp processor
// Operation
// - build up to sixteen signature bytes, valid only for egress frames
// - select 0..23 takes header byte 31 minus select
// - selects 24,25,26 take header bytes 6,4,0; 27 is reserved
// - selects 28..35 take address byte select minus 28
// - each signature byte has its own six-bit select; byte 0 lowest
// - two-bit source picks Ethernet 1, Ethernet 2, IP 1 or IP 2 address
// - each comparator chooses source or destination address to supply
// - address comparator follows whether part A or part B flow matched
// - part B match with Ethernet 2 source gives zero address bytes
// - each flow carries a per-channel mask: A, B or both
// - eight flows shared, split between the channels freely
// - ACH comparison starts right after MPLS comparison ends
// - first Ethernet match reports group A and group B bits
// - later stages accept only groups flagged earlier, pass own bits on
// - output corrected time structure or signed 64-bit correction
// - ingress time is captured minus fixed minus pipeline latency
// - egress time is captured plus fixed plus pipeline latency
// - only event messages are modified, never general ones
// - peer-to-peer ingress correction adds the programmed link delay
// - add flag sign-extends delay asymmetry and adds it to correction
// - subtract flag sign-extends delay asymmetry and subtracts it
// - calculations use shadow copies of latency and delay settings
`timescale 1ns/1ps
`default_nettype none
module ptp_signature_and_timestamp_calc
  import ptp_calc_pkg::*;
(
  input  wire logic                      core_clk,          // port clock
  input  wire logic                      rst,               // async reset, high
  // configuration
  input  wire logic [MAP_W*SIG_BYTES-1:0] signature_byte_map, // 16 x 6-bit selects
  input  wire logic [1:0]                signature_address_source, // address source
  input  wire logic [CMP_COUNT-1:0]      cmp_use_dest,      // per comparator: 1 = DA
  input  wire logic [2*FLOWS-1:0]        flow_channel_mask, // {B,A} per flow
  input  wire logic [FLOWS-1:0]          flow_enable,       // per flow enable
  input  wire logic                      egress,            // 1 = egress path
  input  wire logic                      p2p_mode,          // peer-to-peer TC
  input  wire logic                      add_asym,          // add asymmetry
  input  wire logic                      sub_asym,          // subtract asymmetry
  input  wire logic [31:0]               fixed_latency,     // fixed latency, ns
  input  wire logic [31:0]               link_delay,        // path delay, ns
  input  wire logic [31:0]               delay_asymmetry_value, // scaled ns, signed
  // frame analyzer
  input  wire logic                      channel_sel,       // 0 = channel A
  input  wire logic                      frame_start,       // start-of-frame pulse
  input  wire logic                      frame_end,         // end-of-frame pulse
  input  wire logic [FLOWS-1:0]          flow_hit,          // raw flow matches
  input  wire logic                      part_b_match,      // part B flow matched
  input  wire logic [1:0]                first_eth_grp,     // {B,A} first Ethernet
  input  wire logic [STAGES-1:0]         stage_grp_a,       // later stages, group A
  input  wire logic [STAGES-1:0]         stage_grp_b,       // later stages, group B
  input  wire logic                      mpls_done,         // MPLS compare finished
  input  wire logic [8*HDR_BYTES-1:0]    ptp_header,        // header bytes, 0 low
  input  wire logic [2*8*ADDR_BYTES-1:0] first_ethernet_comparator,  // {DA,SA}
  input  wire logic [2*8*ADDR_BYTES-1:0] second_ethernet_comparator, // {DA,SA}
  input  wire logic [2*8*ADDR_BYTES-1:0] first_ip_comparator,        // {DA,SA}
  input  wire logic [2*8*ADDR_BYTES-1:0] second_ip_comparator,       // {DA,SA}
  input  wire logic                      msg_valid,         // message to process
  input  wire logic                      msg_is_event,      // event message
  input  wire logic                      msg_cmd,           // tsp_cmd_e code
  input  wire ts_s                       raw_timestamp,     // captured time
  input  wire logic [31:0]               pipe_latency,      // predicted, ns
  input  wire logic [63:0]               correction_in,     // frame correction
  // results
  output logic [8*SIG_BYTES-1:0]         signature,         // frame signature
  output logic                           signature_valid,   // one-cycle pulse
  output logic [FLOWS-1:0]               flow_match,        // gated flow matches
  output logic [2*(STAGES+1)-1:0]        group_bits,        // chained groups
  output logic                           ach_start,         // ACH compare start
  output ts_s                            ts_out,            // corrected time
  output logic [63:0]                    correction_out,    // new correction
  output logic                           result_valid,      // one-cycle pulse
  output logic                           result_is_cf       // 1 = correction
);
  import ptp_calc_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TIME,
    ST_NS,
    ST_CORR
  } tsp_state_e;

  // ----------------------------------------
  // helper instances
  // ----------------------------------------
  ptp_calc_if bus ();
  sig_byte_builder  u_builder (.bus(bus.builder));
  proto_group_chain u_chain   (.bus(bus.chain));

  logic [8*ADDR_BYTES-1:0] sel_addr;
  logic [8*ADDR_BYTES-1:0] cmp_addr [CMP_COUNT];

  assign cmp_addr[ADR_FIRST_ETHERNET_COMPARATOR] = first_ethernet_comparator[8*ADDR_BYTES*cmp_use_dest[ADR_FIRST_ETHERNET_COMPARATOR] +: 8*ADDR_BYTES];
  assign cmp_addr[ADR_SECOND_ETHERNET_COMPARATOR] = second_ethernet_comparator[8*ADDR_BYTES*cmp_use_dest[ADR_SECOND_ETHERNET_COMPARATOR] +: 8*ADDR_BYTES];
  assign cmp_addr[ADR_IP1]  = first_ip_comparator[8*ADDR_BYTES*cmp_use_dest[ADR_IP1] +: 8*ADDR_BYTES];
  assign cmp_addr[ADR_IP2]  = second_ip_comparator[8*ADDR_BYTES*cmp_use_dest[ADR_IP2] +: 8*ADDR_BYTES];

  // part B has no second Ethernet comparator, so that choice pads zeros
  always_comb begin
    sel_addr = cmp_addr[signature_address_source];
    if (part_b_match && signature_address_source == ADR_SECOND_ETHERNET_COMPARATOR) begin
      sel_addr = '0;
    end
  end

  assign bus.hdr       = ptp_header;
  assign bus.addr      = sel_addr;
  assign bus.map       = signature_byte_map;
  assign bus.grp_first = first_eth_grp;
  assign bus.stage_a   = stage_grp_a;
  assign bus.stage_b   = stage_grp_b;

  // ----------------------------------------
  // signature and flow gating
  // ----------------------------------------
  logic [FLOWS-1:0] flow_ok;

  genvar f;
  generate
    for (f = 0; f < FLOWS; f++) begin : g_flow
      assign flow_ok[f] = flow_hit[f] & flow_enable[f]
                        & flow_channel_mask[CHANNELS*f + 32'(channel_sel)];
    end
  endgenerate

  // signature only leaves the block for egress frames that matched a flow
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      signature       <= '0;
      signature_valid <= 1'b0;
    end else begin
      signature_valid <= 1'b0;
      if (frame_end && egress && |flow_ok) begin
        signature       <= bus.sig;
        signature_valid <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flow_match <= '0;
      group_bits <= '0;
    end else begin
      flow_match <= flow_ok;
      group_bits <= bus.grp_chain;
    end
  end

  // ACH compare kicks off the cycle after MPLS reports done
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ach_start <= 1'b0;
    end else begin
      ach_start <= mpls_done;
    end
  end

  // ----------------------------------------
  // latency shadows
  // ----------------------------------------
  logic        in_frame_q;
  logic [31:0] fixed_q;
  logic [31:0] link_q;
  logic [31:0] asym_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_frame_q <= 1'b0;
    end else if (frame_start) begin
      in_frame_q <= 1'b1;
    end else if (frame_end) begin
      in_frame_q <= 1'b0;
    end
  end

  // frozen from frame start to frame end so a frame sees one set of values
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fixed_q <= '0;
      link_q  <= '0;
      asym_q  <= '0;
    end else if (!in_frame_q && !frame_start) begin
      fixed_q <= fixed_latency;
      link_q  <= link_delay;
      asym_q  <= delay_asymmetry_value;
    end
  end

  // ----------------------------------------
  // time stamp processor
  // ----------------------------------------
  tsp_state_e  state_q;
  ts_s         raw_q;
  ts_s         act_q;
  logic [31:0] pipe_q;
  logic [63:0] cf_q;
  logic [63:0] act_ns_q;
  logic        cmd_q;
  logic        egr_q;
  logic [32:0] delta;
  logic [33:0] ns_sum;
  logic [33:0] ns_dif;
  ts_s         act_d;
  logic [63:0] cf_d;
  logic [63:0] asym_ext;

  assign delta    = {1'b0, fixed_q} + {1'b0, pipe_q};
  assign ns_sum   = {2'b00, raw_q.ns} + {1'b0, delta};
  assign ns_dif   = {2'b00, raw_q.ns} - {1'b0, delta};
  assign asym_ext = {{32{asym_q[31]}}, asym_q};

  // latencies are assumed well under one second, so at most one wrap
  always_comb begin
    act_d = raw_q;
    if (egr_q) begin
      act_d.ns = ns_sum[31:0];
      if (ns_sum >= {2'b00, NS_PER_SEC}) begin
        act_d.ns  = 32'(ns_sum - {2'b00, NS_PER_SEC});
        act_d.sec = raw_q.sec + 48'h000000000001;
      end
    end else begin
      act_d.ns = ns_dif[31:0];
      if (ns_dif[33]) begin
        act_d.ns  = 32'(ns_dif + {2'b00, NS_PER_SEC});
        act_d.sec = raw_q.sec - 48'h000000000001;
      end
    end
  end

  // the corrected time stamp in ns enters the correction as a signed scaled-ns delta
  always_comb begin
    cf_d = cf_q;
    if (egr_q) begin
      cf_d = cf_q + (act_ns_q << FRAC_BITS);
    end else begin
      cf_d = cf_q - (act_ns_q << FRAC_BITS);
      if (p2p_mode) begin
        cf_d = cf_d + ({32'h00000000, link_q} << FRAC_BITS);
      end
    end
    if (add_asym) begin
      cf_d = cf_d + asym_ext;
    end else if (sub_asym) begin
      cf_d = $signed(cf_d) - $signed(asym_ext);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (msg_valid && msg_is_event) begin
            state_q <= ST_TIME;
          end
        end
        ST_TIME: state_q <= ST_NS;
        ST_NS:   state_q <= ST_CORR;
        ST_CORR: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      raw_q    <= '0;
      pipe_q   <= '0;
      cf_q     <= '0;
      cmd_q    <= 1'b0;
      egr_q    <= 1'b0;
      act_q    <= '0;
      act_ns_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (msg_valid && msg_is_event) begin
            raw_q  <= raw_timestamp;
            pipe_q <= pipe_latency;
            cf_q   <= correction_in;
            cmd_q  <= msg_cmd;
            egr_q  <= egress;
          end
        end
        ST_TIME: act_q <= act_d;
        ST_NS:   act_ns_q <= 64'(act_q.sec * NS_PER_SEC) + {32'h00000000, act_q.ns};
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ts_out         <= '0;
      correction_out <= '0;
      result_valid   <= 1'b0;
      result_is_cf   <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (state_q == ST_CORR) begin
        ts_out         <= act_q;
        correction_out <= cf_d;
        result_is_cf   <= (cmd_q == CMD_CORRECTION);
        result_valid   <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// File: rtl/sig_byte_builder.sv
// frame signature byte selection, one mux per signature byte
`timescale 1ns/1ps
`default_nettype none
module sig_byte_builder (
  ptp_calc_if.builder bus  // header, address, map in; signature out
);
  import ptp_calc_pkg::*;

  genvar g;
  generate
    for (g = 0; g < SIG_BYTES; g++) begin : g_byte
      logic [5:0] sel;
      logic [4:0] hidx;
      logic [2:0] aidx;
      assign sel = bus.map[MAP_W*g +: MAP_W];
      always_comb begin
        hidx = 5'(SEL_HDR_BASE - sel);
        aidx = 3'(sel - SEL_ADDR_LO);
        bus.sig[8*g +: 8] = 8'h00;
        if (sel <= SEL_HDR_MAX) begin
          bus.sig[8*g +: 8] = bus.hdr[8*hidx +: 8];
        end else if (sel == SEL_HDR6) begin
          bus.sig[8*g +: 8] = bus.hdr[8*HDR_IDX6 +: 8];
        end else if (sel == SEL_HDR4) begin
          bus.sig[8*g +: 8] = bus.hdr[8*HDR_IDX4 +: 8];
        end else if (sel == SEL_HDR0) begin
          bus.sig[8*g +: 8] = bus.hdr[8*HDR_IDX0 +: 8];
        end else if (sel >= SEL_ADDR_LO && sel <= SEL_ADDR_HI) begin
          bus.sig[8*g +: 8] = bus.addr[8*aidx +: 8];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// File: verif/analyzer_model.sv
// analyzer side model: frame pulses, header and comparator addresses
`timescale 1ns/1ps
`default_nettype none
module analyzer_model
  import ptp_calc_pkg::*;
(
  input  wire logic                 core_clk,    // port clock
  output logic                      frame_start, // frame begins
  output logic                      frame_end,   // frame ends
  output logic [8*HDR_BYTES-1:0]    ptp_header,  // header, byte 0 low
  output logic [8*CMP_COUNT*16-1:0] cmp_addr     // {ip2,ip1,second_ethernet_comparator,first_ethernet_comparator}
);
  logic in_frame;
  // bytes read inverted outside frames, so a stale capture cannot pass
  always_comb begin
    for (int k = 0; k < HDR_BYTES; k++)
      ptp_header[8*k+:8] = in_frame ? 8'(8'hC0 + k) : ~8'(8'hC0 + k);
    for (int n = 0; n < CMP_COUNT * 16; n++)
      cmp_addr[8*n+:8] = in_frame ? 8'(n + 1) : ~8'(n + 1);
  end
  initial begin
    in_frame = 1'b0;
    frame_start = 1'b0;
    frame_end = 1'b0;
  end
  task automatic run_frame(input int len);
    @(posedge core_clk);
    frame_start <= 1'b1;
    in_frame <= 1'b1;
    @(posedge core_clk);
    frame_start <= 1'b0;
    repeat (len) @(posedge core_clk);
    frame_end <= 1'b1;
    @(posedge core_clk);
    frame_end <= 1'b0;
    in_frame <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: verif/ptp_calc_asserts.sv
// concurrent checks on the signature, group chain and time stamp ports
`timescale 1ns/1ps
`default_nettype none
module ptp_calc_asserts
  import ptp_calc_pkg::*;
(
  input wire logic                      core_clk,          // port clock
  input wire logic                      rst,               // async reset
  input wire logic [2*FLOWS-1:0]        flow_channel_mask, // {B,A} per flow
  input wire logic [FLOWS-1:0]          flow_enable,       // flow enables
  input wire logic                      egress,            // direction
  input wire logic                      channel_sel,       // channel
  input wire logic                      frame_end,         // end of frame
  input wire logic [FLOWS-1:0]          flow_hit,          // raw matches
  input wire logic [1:0]                first_eth_grp,     // first groups
  input wire logic [STAGES-1:0]         stage_grp_a,       // group A
  input wire logic [STAGES-1:0]         stage_grp_b,       // group B
  input wire logic                      mpls_done,         // mpls finished
  input wire logic                      msg_valid,         // message
  input wire logic                      msg_is_event,      // event kind
  input wire logic                      msg_cmd,           // command
  input wire logic                      signature_valid,   // signature out
  input wire logic [FLOWS-1:0]          flow_match,        // gated matches
  input wire logic [2*(STAGES+1)-1:0]   group_bits,        // chained groups
  input wire logic                      ach_start,         // ach start
  input wire logic                      result_valid,      // result pulse
  input wire logic                      result_is_cf       // result kind
);
  // ----------------------------------------
  // reference gating
  // ----------------------------------------
  logic [FLOWS-1:0] ok;
  logic [1:0]       g1;
  logic [1:0]       g2;
  logic [1:0]       g3;
  always_comb begin
    for (int f = 0; f < FLOWS; f++)
      ok[f] = flow_hit[f] & flow_enable[f] & flow_channel_mask[2*f+int'(channel_sel)];
  end
  assign g1 = first_eth_grp & {stage_grp_b[0], stage_grp_a[0]};
  assign g2 = g1 & {stage_grp_b[1], stage_grp_a[1]};
  assign g3 = g2 & {stage_grp_b[2], stage_grp_a[2]};

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ach_timing: assert property (ach_start == $past(mpls_done))
    else $error("ach start not one cycle after mpls done");
  a_flow_gate: assert property (flow_match == $past(ok))
    else $error("flow match differs from gated hits");
  a_group_head: assert property (group_bits[1:0] == $past(first_eth_grp))
    else $error("first group bits wrong");
  a_group_chain: assert property (group_bits[7:2] == $past({g3, g2, g1}))
    else $error("chained group bits wrong");
  a_sig_egress: assert property (signature_valid |-> $past(frame_end && egress))
    else $error("signature without egress frame end");
  a_sig_taken: assert property (frame_end && egress && |ok |=> signature_valid)
    else $error("matched egress frame gave no signature");
  a_result_src: assert property (result_valid |-> $past(msg_valid && msg_is_event, 4))
    else $error("result without event message four cycles before");
  a_result_kind: assert property (result_valid |-> result_is_cf == $past(msg_cmd, 4))
    else $error("result kind differs from command");
  a_result_gap: assert property (result_valid |=> !result_valid [*3])
    else $error("results closer than one operation");
endmodule
bind ptp_signature_and_timestamp_calc ptp_calc_asserts u_ptp_calc_asserts (.*);
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the signature, group chain and time stamp block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ptp_calc_pkg::*;
  logic                       core_clk, rst, egress, p2p_mode, add_asym, sub_asym;
  logic                       channel_sel, part_b_match, mpls_done, msg_valid;
  logic                       msg_is_event, msg_cmd, signature_valid, ach_start;
  logic                       result_valid, result_is_cf, frame_start, frame_end;
  logic [MAP_W*SIG_BYTES-1:0] signature_byte_map;
  logic [1:0]                 signature_address_source, first_eth_grp;
  logic [CMP_COUNT-1:0]       cmp_use_dest;
  logic [2*FLOWS-1:0]         flow_channel_mask;
  logic [FLOWS-1:0]           flow_enable, flow_hit, flow_match;
  logic [31:0]                fixed_latency, link_delay, delay_asymmetry_value;
  logic [31:0]                pipe_latency;
  logic [STAGES-1:0]          stage_grp_a, stage_grp_b;
  logic [8*HDR_BYTES-1:0]     ptp_header;
  logic [511:0]               cmp_addr;
  logic [8*SIG_BYTES-1:0]     signature;
  logic [2*(STAGES+1)-1:0]    group_bits;
  logic [63:0]                correction_in, correction_out;
  ts_s                        raw_timestamp, ts_out;
  wire logic [127:0]          first_ethernet_comparator = cmp_addr[127:0];
  wire logic [127:0]          second_ethernet_comparator = cmp_addr[255:128];
  wire logic [127:0]          first_ip_comparator = cmp_addr[383:256];
  wire logic [127:0]          second_ip_comparator = cmp_addr[511:384];
  int                         n_mismatch = 0;
  int                         n_compared = 0;
  logic [5:0]                 sel [SIG_BYTES] = '{6'h00, 6'h17, 6'h18, 6'h19, 6'h1A,
    6'h1B, 6'h1C, 6'h23, 6'h05, 6'h1E, 6'h0C, 6'h28, 6'h01, 6'h21, 6'h12, 6'h3F};

  ptp_signature_and_timestamp_calc u_ptp_signature_and_timestamp_calc (.*);
  analyzer_model u_analyzer_model (.core_clk(core_clk), .frame_start(frame_start),
    .frame_end(frame_end), .ptp_header(ptp_header), .cmp_addr(cmp_addr));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // header byte k reads C0+k, address byte n reads n+1 inside a frame
  function automatic logic [127:0] exp_sig(input int src, input logic pb);
    logic [127:0] r;
    logic [5:0]   s;
    r = '0;
    for (int i = 0; i < SIG_BYTES; i++) begin
      s = sel[i];
      if (s <= 6'h17)
        r[8*i+:8] = 8'hC0 + 8'(31 - s);
      else if (s == 6'h18)
        r[8*i+:8] = 8'hC6;
      else if (s == 6'h19)
        r[8*i+:8] = 8'hC4;
      else if (s == 6'h1A)
        r[8*i+:8] = 8'hC0;
      else if (s >= 6'h1C && s <= 6'h23 && !(pb && src == 1))
        r[8*i+:8] = 8'(16 * src + 8 * cmp_use_dest[src] + s - 28 + 1);
    end
    return r;
  endfunction

  task automatic frame_case(input logic eg, ch, input logic [7:0] hit, input int src,
                            input logic pb, ev);
    @(posedge core_clk);
    egress <= eg;
    channel_sel <= ch;
    flow_hit <= hit;
    signature_address_source <= 2'(src);
    part_b_match <= pb;
    cmp_use_dest <= pb ? 4'hA : 4'h5;
    u_analyzer_model.run_frame(3);
    #1;
    chk(signature_valid, ev);
    if (ev)
      chk(signature, exp_sig(src, pb));
  endtask

  task automatic timestamp_processor(input logic eg, p2p, ad, sb, cmd, ev, hold, input ts_s raw,
                     input logic [31:0] fx);
    logic [63:0] tot;
    logic [63:0] act;
    logic [63:0] cf;
    logic [63:0] asym;
    ts_s         t;
    tot = raw.sec * 64'(NS_PER_SEC) + 64'(raw.ns);
    act = eg ? tot + fx + pipe_latency : tot - fx - pipe_latency;
    t.sec = 48'(act / 64'(NS_PER_SEC));
    t.ns = 32'(act % 64'(NS_PER_SEC));
    asym = {{32{delay_asymmetry_value[31]}}, delay_asymmetry_value};
    cf = eg ? correction_in + (act << 16) : correction_in - (act << 16);
    if (!eg && p2p)
      cf = cf + (64'(link_delay) << 16);
    if (ad)
      cf = cf + asym;
    else if (sb)
      cf = cf - asym;
    @(posedge core_clk);
    {egress, p2p_mode, add_asym, sub_asym, msg_cmd, msg_is_event} <= {eg, p2p, ad, sb, cmd, ev};
    raw_timestamp <= raw;
    msg_valid <= 1'b1;
    @(posedge core_clk);
    // a held request lands while busy and must vanish
    if (hold)
      @(posedge core_clk);
    msg_valid <= 1'b0;
    repeat (hold ? 2 : 3) @(posedge core_clk);
    #1;
    chk(result_valid, ev);
    if (ev) begin
      chk(result_is_cf, cmd);
      chk(ts_out, t);
      chk(correction_out, cf);
    end
  endtask

  initial begin
    rst = 1'b1;
    {egress, p2p_mode, add_asym, sub_asym, channel_sel, part_b_match} = '0;
    {mpls_done, msg_valid, msg_is_event, msg_cmd} = '0;
    {first_eth_grp, stage_grp_a, stage_grp_b, flow_hit, signature_address_source} = '0;
    for (int i = 0; i < SIG_BYTES; i++)
      signature_byte_map[6*i+:6] = sel[i];
    cmp_use_dest = 4'h5;
    flow_enable = 8'hFD;
    flow_channel_mask = 16'hFFED;
    fixed_latency = 32'h64;
    pipe_latency = 32'h14;
    link_delay = 32'h3E8;
    delay_asymmetry_value = 32'hFFFF8000;
    correction_in = 64'h12340000;
    raw_timestamp = '0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    for (int k = 0; k < 8; k++)
      frame_case(1'b1, 1'b0, 8'h01, k % 4, k >= 4, 1'b1);
    frame_case(1'b0, 1'b0, 8'h01, 0, 1'b0, 1'b0);
    frame_case(1'b1, 1'b0, 8'h02, 0, 1'b0, 1'b0);
    frame_case(1'b1, 1'b1, 8'h01, 0, 1'b0, 1'b0);
    frame_case(1'b1, 1'b1, 8'h04, 1, 1'b0, 1'b1);
    @(posedge core_clk);
    {first_eth_grp, stage_grp_a, stage_grp_b, mpls_done} <= {2'h3, 3'h7, 3'h3, 1'b1};
    @(posedge core_clk);
    mpls_done <= 1'b0;
    #1;
    chk(group_bits, 8'h7F);
    chk(ach_start, 1'b1);
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      {first_eth_grp, stage_grp_a, stage_grp_b, mpls_done} <= 9'(i * 37);
    end
    timestamp_processor(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, '{48'h5, 32'h32}, 32'h64);
    timestamp_processor(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, '{48'h7, 32'h3B9AC9CE}, 32'h64);
    timestamp_processor(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, '{48'h3, 32'h1000}, 32'h64);
    timestamp_processor(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, '{48'h3, 32'h1000}, 32'h64);
    timestamp_processor(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, '{48'h3, 32'h1000}, 32'h64);
    fork
      u_analyzer_model.run_frame(14);
    join_none
    repeat (3) @(posedge core_clk);
    fixed_latency <= 32'h1F4;
    timestamp_processor(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, '{48'h2, 32'h64}, 32'h64);
    wait fork;
    repeat (2) @(posedge core_clk);
    timestamp_processor(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, '{48'h2, 32'h64}, 32'h1F4);
    complete_run();
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
